// >>> verilog/npic_params.svh
// register indices, field positions, reset values of the priority unit
`ifndef NPIC_PARAMS_SVH
`define NPIC_PARAMS_SVH

// ----------------------------------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------------------------------
`define NPIC_IDX_LVL0        6'h30
`define NPIC_IDX_LVL1        6'h31
`define NPIC_IDX_PRIO_CTRL   6'h32
`define NPIC_IDX_EXT_PIN     6'h3b

// ----------------------------------------------------------------
// prio_ctrl_status_reg fields
// ----------------------------------------------------------------
`define NPIC_PC_MASK_LSB     0
`define NPIC_PC_PULL_BIT     4
`define NPIC_PC_EMPTY_BIT    5
`define NPIC_PC_FULL_BIT     6
`define NPIC_PC_EN_BIT       7
`define NPIC_PC_RESET        8'h00

// ----------------------------------------------------------------
// external_pin_irq_status_control fields
// ----------------------------------------------------------------
`define NPIC_EP_MODE_BIT     0
`define NPIC_EP_IE_BIT       1
`define NPIC_EP_ACK_BIT      2
`define NPIC_EP_FLAG_BIT     3
`define NPIC_EP_PE_BIT       4
`define NPIC_EP_EDG_BIT      5
`define NPIC_EP_PDD_BIT      6
`define NPIC_EP_RESET        8'h00

// ----------------------------------------------------------------
// pseudo-stack
// ----------------------------------------------------------------
`define NPIC_STACK_DEPTH     4
`define NPIC_LVLS_PER_WORD   16

`endif

// >>> verilog/npic_pkg.sv
// types shared by the priority unit files
package npic_pkg;

    typedef logic [1:0] npic_level_t;

    typedef enum logic [1:0]
    {
        NPIC_BUS_IDLE = 2'b01,
        NPIC_BUS_ACK  = 2'b10
    } npic_bus_e;

endpackage

// >>> verilog/npic_pin_if.sv
// link between the controller and the external pin detector
`timescale 1ns/1ps

interface npic_pin_if;
    logic pin_en;
    logic edge_pol;
    logic mode_sel;
    logic pull_dis;
    logic irq_en;
    logic ack_pulse;
    logic flag;
    logic pin_req;

    modport ctrl
    (
        output pin_en,
        output edge_pol,
        output mode_sel,
        output pull_dis,
        output irq_en,
        output ack_pulse,
        input  flag,
        input  pin_req
    );

    modport pin
    (
        input  pin_en,
        input  edge_pol,
        input  mode_sel,
        input  pull_dis,
        input  irq_en,
        input  ack_pulse,
        output flag,
        output pin_req
    );
endinterface

// >>> verilog/npic_ext_pin.sv
// external interrupt pin detector with pull-up and wake path
`timescale 1ns/1ps
`include "npic_params.svh"

module npic_ext_pin
(
    input  wire logic  clk,
    input  wire logic  rst,
    npic_pin_if.pin    pif,
    input  wire logic  pin_in,
    input  wire logic  stop_mode,
    output logic       pin_level,
    output logic       pullup_en,
    output logic       wake_async
);

    logic sync1_r;
    logic sync2_r;
    logic act_prev_r;
    logic en_prev_r;
    logic flag_r;
    logic active;
    logic edge_hit;
    logic set_flag;

    // ----------------------------------------------------------------
    // synchroniser
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sync1_r <= 1'b1;
            sync2_r <= 1'b1;
        end
        else
        begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
        end
    end

    assign pin_level = sync2_r;

    // ----------------------------------------------------------------
    // detection
    // ----------------------------------------------------------------
    // polarity select
    assign active = pif.edge_pol ? sync2_r : ~sync2_r;
    assign edge_hit = active & ~act_prev_r;
    assign set_flag = pif.pin_en &
                      (edge_hit | (pif.mode_sel & active) | ~en_prev_r);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            act_prev_r <= 1'b0;
            en_prev_r  <= 1'b0;
        end
        else
        begin
            act_prev_r <= active;
            en_prev_r  <= pif.pin_en;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            flag_r <= 1'b0;
        else if (set_flag)
            flag_r <= 1'b1;
        else if (pif.ack_pulse || !pif.pin_en)
            flag_r <= 1'b0;
    end

    assign pif.flag = flag_r;
    assign pif.pin_req = flag_r & pif.irq_en & pif.pin_en;

    assign pullup_en = pif.pin_en & ~pif.pull_dis & ~pif.edge_pol;

    assign wake_async = stop_mode & pif.pin_en &
                        (pif.edge_pol ? pin_in : ~pin_in);

endmodule // npic_ext_pin

// >>> verilog/npic_ctrl.sv
// nested priority interrupt gating unit with wishbone registers
//
// Function
// - every source has a 2-bit level, 3 highest, 0 lowest
// - level registers readable and writable any time, used live
// - enabled unit passes a request when its level >= priority mask
// - in stop3 the compare uses mask zero
// - disabled unit forwards requests unchanged
// - CPU fixed arbitration still picks among passed requests
// - priority mask sits in bits 1:0 of control/status register
// - vector fetch loads mask with serviced source level
// - every vector fetch pushes old mask onto four-deep stack
// - writing 1 to restore pull bit pops mask from stack
// - full flag set when fourth stack slot written
// - empty flag set when all saved values popped
// - asynchronous requests bypass the unit to the wake logic
// - masked pin still readable for branch instructions
// - pin acts as interrupt only while its enable bit is 1
// - pin has polarity, edge/level mode, interrupt or poll choice
// - pull-up on while pull disable is 0, off when 1
// - enabled pin watched by synchronous logic with clocks running
// - in stop, enabled pin event reaches an asynchronous wake path
// - enabling pin sets its flag; software clears before enabling irq
// - level mode keeps flag set while pin stays asserted
// - polarity 0 falling/low, 1 rising/high
// - rising edge config disables pull-up regardless of disable bit
//
// Chosen here: register access over Wishbone.
`timescale 1ns/1ps
`include "npic_params.svh"

module npic_ctrl
#(
    parameter int N_SRC   = 32,
    parameter int EXT_SRC = 2
)
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    input  wire logic [N_SRC-1:0]  src_req,
    input  wire logic [N_SRC-1:0]  src_async_req,
    output logic      [N_SRC-1:0]  gated_request_out,
    output logic      [N_SRC-1:0]  async_wake_out,
    input  wire logic              vec_fetch,
    input  wire logic [4:0]        vec_src,
    input  wire logic              stop3_mode,
    input  wire logic              ext_pin_in,
    output logic                   ext_pin_level,
    output logic                   ext_pullup_en,
    output logic                   ext_wake_async
);

    localparam int DEPTH = `NPIC_STACK_DEPTH;
    localparam int LPW   = `NPIC_LVLS_PER_WORD;

    npic_pin_if pif ();

    npic_pkg::npic_bus_e    bus_r;
    npic_pkg::npic_level_t  lvl_r [N_SRC];
    npic_pkg::npic_level_t  priority_mask_r;
    npic_pkg::npic_level_t  mask_pseudo_stack_r [DEPTH];
    logic [2:0]             depth_r;
    logic                   unit_en_r;
    logic [7:0]             ext_cfg_r;
    logic [31:0]            rdata_r;
    logic                   req_valid;
    logic                   wr_stb;
    logic [5:0]             idx;
    logic [31:0]            wmask;
    logic                   restore_mask_pull;
    logic                   stack_full_flag;
    logic                   stack_empty_flag;
    logic [N_SRC-1:0]       req_all;
    logic [N_SRC-1:0]       ext_req_vec;
    npic_pkg::npic_level_t  eff_mask;
    npic_pkg::npic_level_t  fetch_lvl;
    logic [7:0]             prio_ctrl_status_reg;
    logic [7:0]             ext_pin_status_ctrl;

    // ----------------------------------------------------------------
    // helper functions
    // ----------------------------------------------------------------
    function automatic logic [31:0] byte_mask(input logic [3:0] sel);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int b = 0; b < 4; b++)
            m[b*8 +: 8] = {8{sel[b]}};
        return m;
    endfunction

    function automatic logic hit(input logic [5:0] a,
                                 input logic [5:0] want);
        return a == want;
    endfunction

    // ----------------------------------------------------------------
    // wishbone slave
    // ----------------------------------------------------------------
    assign req_valid = wb_cyc_i & wb_stb_i & (bus_r == npic_pkg::NPIC_BUS_IDLE);
    assign wr_stb    = req_valid & wb_we_i;
    assign idx       = wb_adr_i[7:2];
    assign wmask     = byte_mask(wb_sel_i);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            bus_r <= npic_pkg::NPIC_BUS_IDLE;
        else
        begin
            case (bus_r)
                npic_pkg::NPIC_BUS_IDLE:
                    if (req_valid)
                        bus_r <= npic_pkg::NPIC_BUS_ACK;
                npic_pkg::NPIC_BUS_ACK:
                    bus_r <= npic_pkg::NPIC_BUS_IDLE;
                default:
                    bus_r <= npic_pkg::NPIC_BUS_IDLE;
            endcase
        end
    end

    assign wb_ack_o = (bus_r == npic_pkg::NPIC_BUS_ACK);
    assign wb_dat_o = rdata_r;

    // ----------------------------------------------------------------
    // source level registers
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < N_SRC; gi++)
        begin : g_lvl
            localparam logic [5:0] WIDX = (gi / LPW == 0) ?
                                          `NPIC_IDX_LVL0 : `NPIC_IDX_LVL1;
            localparam int         POS  = (gi % LPW) * 2;
            always_ff @(posedge clk or posedge rst)
            begin
                if (rst)
                    lvl_r[gi] <= 2'h0;
                else if (wr_stb && hit(idx, WIDX))
                    lvl_r[gi] <= (wb_dat_i[POS +: 2] & wmask[POS +: 2]) |
                                 (lvl_r[gi] & ~wmask[POS +: 2]);
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // mask, pseudo-stack and control
    // ----------------------------------------------------------------
    assign restore_mask_pull = wr_stb & hit(idx, `NPIC_IDX_PRIO_CTRL) &
                               wb_sel_i[0] & wb_dat_i[`NPIC_PC_PULL_BIT];
    assign stack_full_flag  = (depth_r == 3'(DEPTH));
    assign stack_empty_flag = (depth_r == 3'h0);
    assign fetch_lvl        = lvl_r[vec_src];

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            unit_en_r <= 1'b0;
        else if (wr_stb && hit(idx, `NPIC_IDX_PRIO_CTRL) && wb_sel_i[0])
            unit_en_r <= wb_dat_i[`NPIC_PC_EN_BIT];
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            priority_mask_r <= 2'h0;
            depth_r         <= 3'h0;
            for (int k = 0; k < DEPTH; k++)
                mask_pseudo_stack_r[k] <= 2'h0;
        end
        else if (vec_fetch)
        begin
            priority_mask_r <= fetch_lvl;
            mask_pseudo_stack_r[0] <= priority_mask_r;
            for (int k = 1; k < DEPTH; k++)
                mask_pseudo_stack_r[k] <= mask_pseudo_stack_r[k-1];
            if (!stack_full_flag)
                depth_r <= depth_r + 3'h1;
        end
        else if (restore_mask_pull)
        begin
            if (!stack_empty_flag)
            begin
                priority_mask_r <= mask_pseudo_stack_r[0];
                for (int k = 0; k < DEPTH - 1; k++)
                    mask_pseudo_stack_r[k] <= mask_pseudo_stack_r[k+1];
                mask_pseudo_stack_r[DEPTH-1] <= 2'h0;
                depth_r <= depth_r - 3'h1;
            end
        end
        else if (wr_stb && hit(idx, `NPIC_IDX_PRIO_CTRL) && wb_sel_i[0])
            priority_mask_r <= wb_dat_i[`NPIC_PC_MASK_LSB +: 2];
    end

    // ----------------------------------------------------------------
    // external pin register
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            ext_cfg_r <= `NPIC_EP_RESET;
        else if (wr_stb && hit(idx, `NPIC_IDX_EXT_PIN) && wb_sel_i[0])
            ext_cfg_r <= wb_dat_i[7:0];
    end

    assign pif.pin_en    = ext_cfg_r[`NPIC_EP_PE_BIT];
    assign pif.edge_pol  = ext_cfg_r[`NPIC_EP_EDG_BIT];
    assign pif.mode_sel  = ext_cfg_r[`NPIC_EP_MODE_BIT];
    assign pif.pull_dis  = ext_cfg_r[`NPIC_EP_PDD_BIT];
    assign pif.irq_en    = ext_cfg_r[`NPIC_EP_IE_BIT];
    assign pif.ack_pulse = wr_stb & hit(idx, `NPIC_IDX_EXT_PIN) &
                           wb_sel_i[0] & wb_dat_i[`NPIC_EP_ACK_BIT];

    npic_ext_pin u_pin
    (
        .clk        (clk),
        .rst        (rst),
        .pif        (pif),
        .pin_in     (ext_pin_in),
        .stop_mode  (stop3_mode),
        .pin_level  (ext_pin_level),
        .pullup_en  (ext_pullup_en),
        .wake_async (ext_wake_async)
    );

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    always_comb
    begin
        prio_ctrl_status_reg = 8'h00;
        prio_ctrl_status_reg[`NPIC_PC_MASK_LSB +: 2] = priority_mask_r;
        prio_ctrl_status_reg[`NPIC_PC_EMPTY_BIT]     = stack_empty_flag;
        prio_ctrl_status_reg[`NPIC_PC_FULL_BIT]      = stack_full_flag;
        prio_ctrl_status_reg[`NPIC_PC_EN_BIT]        = unit_en_r;
        ext_pin_status_ctrl = ext_cfg_r & 8'h73;
        ext_pin_status_ctrl[`NPIC_EP_FLAG_BIT] = pif.flag;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            rdata_r <= 32'h0000_0000;
        else if (req_valid)
        begin
            rdata_r <= 32'h0000_0000;
            if (hit(idx, `NPIC_IDX_PRIO_CTRL))
                rdata_r <= {24'h00_0000, prio_ctrl_status_reg};
            else if (hit(idx, `NPIC_IDX_EXT_PIN))
                rdata_r <= {24'h00_0000, ext_pin_status_ctrl};
            else
                for (int s = 0; s < N_SRC; s++)
                    if ((s / LPW == 0 && hit(idx, `NPIC_IDX_LVL0)) ||
                        (s / LPW == 1 && hit(idx, `NPIC_IDX_LVL1)))
                        rdata_r[(s % LPW)*2 +: 2] <= lvl_r[s];
        end
    end

    // ----------------------------------------------------------------
    // gating
    // ----------------------------------------------------------------
    // stop3 forces mask zero
    assign eff_mask = stop3_mode ? 2'h0 : priority_mask_r;

    generate
        for (gi = 0; gi < N_SRC; gi++)
        begin : g_gate
            if (gi == EXT_SRC)
            begin : g_ext
                assign ext_req_vec[gi] = pif.pin_req;
            end
            else
            begin : g_src
                assign ext_req_vec[gi] = 1'b0;
            end
        end
    endgenerate

    assign req_all = src_req | ext_req_vec;

    generate
        for (gi = 0; gi < N_SRC; gi++)
        begin : g_out
            assign gated_request_out[gi] = unit_en_r ?
                (req_all[gi] & (lvl_r[gi] >= eff_mask)) : req_all[gi];
        end
    endgenerate

    assign async_wake_out = src_async_req;

endmodule // npic_ctrl

// >>> bench/npic_ctrl_assertions.sv
// port-level checker for the priority gating unit
`timescale 1ns/1ps
`include "npic_params.svh"

module npic_ctrl_assertions
#(
    parameter int N_SRC = 32
)
(
    input wire logic             clk,
    input wire logic             rst,
    input wire logic             wb_cyc_i,
    input wire logic             wb_stb_i,
    input wire logic             wb_we_i,
    input wire logic [7:0]       wb_adr_i,
    input wire logic [3:0]       wb_sel_i,
    input wire logic [31:0]      wb_dat_i,
    input wire logic             wb_ack_o,
    input wire logic [N_SRC-1:0] src_req,
    input wire logic [N_SRC-1:0] src_async_req,
    input wire logic [N_SRC-1:0] gated_request_out,
    input wire logic [N_SRC-1:0] async_wake_out,
    input wire logic             stop3_mode,
    input wire logic             ext_pin_in,
    input wire logic             ext_pin_level,
    input wire logic             ext_pullup_en,
    input wire logic             ext_wake_async
);
    // line 2 also carries the pin request, so it is left out
    localparam logic [N_SRC-1:0] NP = ~(N_SRC'(32'h4));
    logic       take;
    logic       en_r;
    logic [2:0] ep_r;
    logic [1:0] up_r;

    // ----------------------------------------------------------------
    // shadow of the enable and pin configuration bits
    // ----------------------------------------------------------------
    assign take = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            en_r <= 1'b0;
        else if (take && wb_adr_i[7:2] == `NPIC_IDX_PRIO_CTRL)
            en_r <= wb_dat_i[7];
    end

    // pdd, edg, pe
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            ep_r <= 3'h0;
        else if (take && wb_adr_i[7:2] == `NPIC_IDX_EXT_PIN)
            ep_r <= wb_dat_i[6:4];
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            up_r <= 2'h0;
        else if (up_r != 2'h3)
            up_r <= up_r + 2'h1;
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_async_bypass: assert property (async_wake_out == src_async_req)
        else $error("async request not bypassed");
    a_disabled_pass: assert property
        (!en_r |-> ((gated_request_out ^ src_req) & NP) == '0)
        else $error("disabled unit changed a request");
    a_stop3_pass: assert property
        (en_r && stop3_mode |-> ((gated_request_out ^ src_req) & NP) == '0)
        else $error("stop3 compare did not use zero mask");
    a_gate_needs_req: assert property
        ((gated_request_out & ~src_req & NP) == '0)
        else $error("gated output without request");
    a_pullup_rule: assert property
        (ext_pullup_en == (ep_r[0] & ~ep_r[2] & ~ep_r[1]))
        else $error("pull-up state wrong");
    a_wake_path: assert property
        (ext_wake_async == (stop3_mode & ep_r[0] & (ext_pin_in == ep_r[1])))
        else $error("wake path wrong");
    a_pin_sync: assert property
        (up_r == 2'h3 |-> ext_pin_level == $past(ext_pin_in, 2))
        else $error("pin level not two-stage synchronised");
    a_ack_next: assert property
        (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus answer not a one-cycle ack");
    a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
        else $error("ack without request");
endmodule // npic_ctrl_assertions

bind npic_ctrl npic_ctrl_assertions #(.N_SRC(N_SRC)) u_chk
(
    .clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .src_req(src_req),
    .src_async_req(src_async_req), .gated_request_out(gated_request_out),
    .async_wake_out(async_wake_out), .stop3_mode(stop3_mode),
    .ext_pin_in(ext_pin_in), .ext_pin_level(ext_pin_level),
    .ext_pullup_en(ext_pullup_en), .ext_wake_async(ext_wake_async)
);

// >>> bench/npic_cpu_model.sv
// cpu side: picks a gated request and fetches its vector
`timescale 1ns/1ps

module npic_cpu_model
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [31:0] req,
    input  wire logic        go,
    output logic             vec_fetch,
    output logic [4:0]       vec_src
);
    function automatic logic [4:0] npic_pick(input logic [31:0] r);
        logic [4:0] s;
        s = 5'h0;
        for (int i = 31; i >= 0; i--)
            if (r[i])
                s = 5'(i);
        return s;
    endfunction

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            vec_fetch <= 1'b0;
            vec_src   <= 5'h0;
        end
        else
        begin
            vec_fetch <= go && (req != 32'h0);
            vec_src   <= npic_pick(req);
        end
    end
endmodule // npic_cpu_model

// >>> bench/test_nested_priority_interrupt_ctrl.sv
// testbench of the priority gating unit and pin detector
`timescale 1ns/1ps

module test_nested_priority_interrupt_ctrl;
    typedef struct { logic [7:0] ctrl; logic s3; logic [31:0] exp; } npic_row_s;
    logic        clk, rst, cyc, stb, we, ack, vf, stop3, pin, go;
    logic        plvl, pup, ewake;
    logic [7:0]  adr;
    logic [31:0] dat, dat_o, req, areq, gated, wake, q;
    logic [4:0]  vs;
    int          miscompares, samples_checked;
    npic_row_s   rows [6];
    int          fsrc [4] = '{1, 3, 4, 4};

    npic_ctrl u_dut
    (
        .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .src_req(req), .src_async_req(areq),
        .gated_request_out(gated), .async_wake_out(wake), .vec_fetch(vf),
        .vec_src(vs), .stop3_mode(stop3), .ext_pin_in(pin),
        .ext_pin_level(plvl), .ext_pullup_en(pup), .ext_wake_async(ewake)
    );

    npic_cpu_model u_cpu
    (
        .clk(clk), .rst(rst), .req(gated), .go(go), .vec_fetch(vf),
        .vec_src(vs)
    );

    always #5 clk = ~clk;

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic stop_test;
        $display("checked %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            miscompares++;
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        n = 0;
        // ack is read at the rising edge, before that edge's updates land
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1)
        begin
            miscompares++;
            stop_test();
        end
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic waitc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        clk = 0; rst = 1; cyc = 0; stb = 0; we = 0; adr = 8'h0; dat = 32'h0;
        req = 32'h0; areq = 32'h0; stop3 = 0; pin = 1; go = 0;
        miscompares = 0; samples_checked = 0;
        rows = '{'{8'h00, 0, 32'h1b}, '{8'h80, 0, 32'h1b}, '{8'h81, 0, 32'h1a},
                 '{8'h82, 0, 32'h18}, '{8'h83, 0, 32'h10}, '{8'h83, 1, 32'h1b}};
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        // src0 lvl0, src1 lvl1, src3 lvl2, src4 lvl3
        bus(1, 8'hc0, 32'h384);
        bus(0, 8'hc0, 32'h0);
        chk("lvl0", 32'h384, q);
        bus(1, 8'h00, 32'hffff);
        bus(0, 8'h00, 32'h0);
        chk("unmapped", 32'h0, q);
        foreach (rows[i])
        begin
            req   <= 32'h1b;
            areq  <= 32'h1b ^ i;
            stop3 <= rows[i].s3;
            bus(1, 8'hc8, {24'h0, rows[i].ctrl});
            chk("gated", rows[i].exp, gated);
            chk("bypass", 32'h1b ^ i, wake);
            bus(0, 8'hc8, 32'h0);
            chk("ctrl", {24'h0, rows[i].ctrl}, q & 32'h83);
        end
        stop3 <= 1'b0;
        bus(1, 8'hc8, 32'h80);
        foreach (fsrc[i])
        begin
            req <= 32'h1 << fsrc[i];
            @(posedge clk);
            go <= 1'b1;
            @(posedge clk);
            go <= 1'b0;
            waitc(3);
            bus(0, 8'hc8, 32'h0);
            chk("push", (i == 3) ? 32'h43 : i + 1, q & 32'h43);
        end
        for (int i = 3; i >= 0; i--)
        begin
            bus(1, 8'hc8, 32'h90 | i);
            bus(0, 8'hc8, 32'h0);
            chk("pull", (i == 0) ? 32'h20 : i, q & 32'h63);
        end
        req <= 32'h0;
        bus(1, 8'hec, 32'h10);
        bus(0, 8'hec, 32'h0);
        chk("pin_on", 32'h18, q);
        chk("pullup", 32'h1, pup);
        bus(1, 8'hec, 32'h14);
        bus(0, 8'hec, 32'h0);
        chk("pin_ack", 32'h10, q);
        bus(1, 8'hec, 32'h13);
        pin <= 1'b0;
        waitc(5);
        chk("pin_req", 32'h4, gated);
        bus(1, 8'hec, 32'h17);
        bus(0, 8'hec, 32'h0);
        chk("lvl_hold", 32'h1b, q);
        bus(1, 8'hc8, 32'h81);
        chk("masked", 32'h0, gated);
        chk("pin_lvl", 32'h0, plvl);
        pin <= 1'b1;
        waitc(5);
        bus(1, 8'hec, 32'h17);
        bus(0, 8'hec, 32'h0);
        chk("lvl_rel", 32'h13, q);
        bus(1, 8'hec, 32'h30);
        chk("rise_pull", 32'h0, pup);
        stop3 <= 1'b1;
        waitc(1);
        chk("wake", 32'h1, ewake);
        bus(1, 8'hec, 32'h50);
        chk("pdd", 32'h0, pup);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        bus(0, 8'hec, 32'h0);
        chk("rst_ep", 32'h0, q);
        bus(0, 8'hc8, 32'h0);
        chk("rst_pc", 32'h0, q & 32'h83);
        stop_test();
    end
endmodule // test_nested_priority_interrupt_ctrl
